// >>> src/sfseq_dev.sv
// Flash end: suspend/resume of program and erase, OTP read and program
// Function
// - Suspend code pauses running program or erase
// - Suspend sets program or erase suspend flag
// - Ready bit rises after latency; host polls it
// - Near completion, finish and clear suspend flag
// - Suspend state volatile; flags reset to 80h
// - One nested program suspend inside erase suspend
// - Program suspended: suspended sector reads undefined
// - Erase suspended: program/read elsewhere, sector undefined
// - Program into erase-suspended sector fails, keeps WEL
// - Resumed erase ignores lock changes
// - Resume sets busy when suspended, else ignored
// - Single-phase commands; octal uses all lines
// - Address on rising edge, data on falling
// - OTP read increments, sticks at 0x40
// - OTP program needs write enable latch
// - OTP program starts at chip-select rise
// - At most 65 OTP bytes, rest dropped
// - Busy during OTP program; WEL always cleared
// - OTP timeout clears WEL, sets fail flag
// - Bad byte boundary: no execution, WEL kept
// - Host waits for ready bit after OTP
// - Byte 64 locks the OTP array
// - Lock bit permanent; later programs flag errors
// - No suspend accepted in standby
`timescale 1ns/100ps
`default_nettype none
module sfseq_dev import sfseq_pkg::*; #(
  parameter int PROG_CYC = PROG_NS * CLK_MHZ / 1000,
  parameter int ERASE_CYC = ERASE_NS * CLK_MHZ / 1000,
  parameter int OTP_CYC = OTP_PROG_NS * CLK_MHZ / 1000,
  parameter int CW = 24
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // Link pins
  sfseq_if.dev LINK,
  // Configuration and fault input
  input wire logic OCTAL,
  input wire logic OTP_FAIL,
  // Array read port
  output logic [31:0] ARRAY_ADDR,
  input wire logic [7:0] ARRAY_RDATA
);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [14:0] sect(input logic [31:0] a);
    return a[31:SECT_LSB];
  endfunction

  function automatic logic [7:0] data_start(input logic [7:0] c);
    if (c == OPC_RDSR || c == OPC_RDFS) return 8'h01;
    if (c == OPC_READ) return IDX_READ_DATA;
    if (c == OPC_OTP_RD) return IDX_OTP_DATA;
    return 8'h00;
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] cs_sr;
  logic [2:0] sck_sr;
  logic [7:0] io_m;
  logic [7:0] io_s;

  // Link pins come from the host, so each passes two flops first
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      cs_sr <= 3'h7;
      sck_sr <= 3'h0;
      io_m <= 8'h00;
      io_s <= 8'h00;
    end else begin
      cs_sr <= {cs_sr[1:0], LINK.cs_n};
      sck_sr <= {sck_sr[1:0], LINK.sck};
      io_m <= LINK.serial_io_lines;
      io_s <= io_m;
    end
  end

  // ****************************************
  // Frame decode
  // ****************************************
  logic [2:0] bitcnt;
  logic [7:0] bidx;
  logic [6:0] shin;
  logic [7:0] cmd;
  logic [31:0] addr;
  logic [31:0] rd_addr;
  logic [6:0] otp_idx;
  logic [6:0] otp_n;
  logic [7:0] tx;
  logic drive;
  op_t act;
  logic [CW-1:0] act_cnt;
  logic [31:0] act_addr;
  logic susping;
  logic [CW-1:0] lat_cnt;
  logic p_held;
  logic e_held;
  logic [CW-1:0] p_cnt;
  logic [CW-1:0] e_cnt;
  logic [31:0] p_addr;
  logic [31:0] e_addr;
  logic wel;
  logic [7:0] fsr;
  logic [7:0] otp_rdata;
  logic locked;

  // Edges seen on the second synchroniser stage against a third copy
  wire cs_lo = !cs_sr[1];
  wire frame_go = cs_sr[2] & !cs_sr[1];
  wire frame_end = !cs_sr[2] & cs_sr[1];
  wire rise = cs_lo & sck_sr[1] & !sck_sr[2];
  wire fall = cs_lo & !sck_sr[1] & sck_sr[2];
  wire [7:0] rx_byte = OCTAL ? io_s : {shin, io_s[0]};
  wire byte_done = rise & (OCTAL | bitcnt == 3'h7);
  wire [7:0] ds = data_start(cmd);
  wire ld = fall & (bitcnt == 3'h0) & (ds != 8'h00) & (bidx >= ds);
  wire shift = fall & drive & (bitcnt != 3'h0);
  wire otp_free = act != OP_OTP;
  wire stg_clr = byte_done & (bidx == 8'h00) & (rx_byte == OPC_OTP_PROG) & otp_free;
  wire stg_we = byte_done & (cmd == OPC_OTP_PROG) & (bidx >= IDX_PROG_DATA) & otp_free
    & (otp_n < OTP_MAX_BYTES) & (otp_idx <= OTP_LAST);

  // ****************************************
  // Command acceptance at chip-select rise
  // ****************************************
  wire at_end = frame_end & (bitcnt == 3'h0);
  wire one_byte = at_end & (bidx == 8'h01);
  wire idle = act == OP_NONE;
  wire is_pe = (act == OP_PROG) | (act == OP_ERASE);
  wire go_susp = one_byte & (cmd == OPC_SUSP) & is_pe & !susping;
  wire late = act_cnt <= CW'(SUSP_LAT_CYC);
  wire go_res = one_byte & (cmd == OPC_RESUME) & idle & (p_held | e_held);
  wire go_wren = one_byte & (cmd == OPC_WREN);
  wire go_clfs = one_byte & (cmd == OPC_CLFS);
  wire prog_ok = at_end & (cmd == OPC_PROG) & (bidx > IDX_PROG_DATA) & wel & idle & !p_held;
  wire prog_hit = e_held & (sect(addr) == sect(e_addr));
  wire go_prog = prog_ok & !prog_hit;
  wire bad_prog = prog_ok & prog_hit;
  wire go_erase = at_end & (cmd == OPC_ERASE) & (bidx == IDX_READ_DATA) & wel & idle
    & !p_held & !e_held;
  wire otp_ok = at_end & (cmd == OPC_OTP_PROG) & (bidx > IDX_PROG_DATA) & wel & idle
    & !p_held & !e_held;
  wire go_otp = otp_ok & !locked;
  wire bad_otp = otp_ok & locked;
  wire done = !idle & (act_cnt == CW'(1));
  wire lat_end = susping & (lat_cnt == CW'(1));
  wire otp_fail = done & (act == OP_OTP) & OTP_FAIL;
  wire otp_commit = done & (act == OP_OTP) & !OTP_FAIL;

  // Flag updates merged so that a set in the same cycle beats a clear
  wire [7:0] fs_set = (go_susp ? ((act == OP_PROG) ? FS_PSUS_M : FS_ESUS_M) : 8'h00)
    | (bad_prog ? FS_PERR_M : 8'h00) | (bad_otp ? (FS_PERR_M | FS_PROT_M) : 8'h00)
    | (otp_fail ? FS_PERR_M : 8'h00);
  wire [7:0] fs_clr = (go_clfs ? (FS_PERR_M | FS_PROT_M) : 8'h00)
    | ((done & act == OP_PROG) ? FS_PSUS_M : 8'h00)
    | ((done & act == OP_ERASE) ? FS_ESUS_M : 8'h00)
    | (go_res ? (p_held ? FS_PSUS_M : FS_ESUS_M) : 8'h00);
  wire [7:0] next_fsr = (fsr & ~fs_clr) | fs_set;

  // Register values as shifted out; ready is low whenever an operation runs
  wire [7:0] sr_val = (idle ? 8'h00 : SR_WIP_M) | (wel ? SR_WEL_M : 8'h00);
  wire [7:0] fs_val = (fsr & ~FS_READY_M) | (idle ? FS_READY_M : 8'h00);
  wire undef = (p_held & sect(rd_addr) == sect(p_addr))
    | (e_held & sect(rd_addr) == sect(e_addr));
  wire [7:0] tx_src = (cmd == OPC_RDSR) ? sr_val : (cmd == OPC_RDFS) ? fs_val
    : (cmd == OPC_OTP_RD) ? otp_rdata : undef ? UNDEF_BYTE : ARRAY_RDATA;

  assign ARRAY_ADDR = rd_addr;
  assign LINK.dev_io = OCTAL ? tx : {6'h00, tx[7], 1'b0};
  assign LINK.dev_oe_n = !drive ? 8'hFF : OCTAL ? 8'h00 : 8'hFD;

  // ****************************************
  // Shift logic
  // ****************************************
  // Bit and byte counters restart with every frame
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N || frame_go) begin
      bitcnt <= 3'h0;
      bidx <= 8'h00;
      shin <= 7'h00;
      cmd <= 8'h00;
    end else if (rise) begin
      bitcnt <= OCTAL ? 3'h0 : bitcnt + 3'h1;
      shin <= {shin[5:0], io_s[0]};
      if (byte_done && bidx != 8'hFF) bidx <= bidx + 8'h01;
      if (byte_done && bidx == 8'h00) cmd <= rx_byte;
    end
  end

  // Address capture and the read/OTP pointers
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      addr <= 32'h0;
      rd_addr <= 32'h0;
      otp_idx <= 7'h00;
      otp_n <= 7'h00;
    end else begin
      if (frame_go) otp_n <= 7'h00;
      if (byte_done && bidx >= 8'h01 && bidx <= IDX_ADDR_LAST) addr <= {addr[23:0], rx_byte};
      if (byte_done && bidx == IDX_ADDR_LAST) begin
        rd_addr <= {addr[23:0], rx_byte};
        otp_idx <= (rx_byte > {1'b0, OTP_LAST}) ? OTP_LAST : rx_byte[6:0];
      end else if (ld) begin
        rd_addr <= rd_addr + 32'h1;
        if (otp_idx != OTP_LAST) otp_idx <= otp_idx + 7'h01;
      end else if (stg_we) begin
        otp_idx <= otp_idx + 7'h01;
        otp_n <= otp_n + 7'h01;
      end
    end
  end

  // Output byte: loaded at a byte's first falling edge, then shifted; ends with the frame
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      tx <= 8'h00;
      drive <= 1'b0;
    end else begin
      drive <= cs_lo & (drive | ld);
      if (ld) tx <= tx_src;
      else if (shift) tx <= {tx[6:0], 1'b0};
    end
  end

  // ****************************************
  // Operation engine
  // ****************************************
  // Suspend keeps the remaining count; reset drops everything held
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      act <= OP_NONE;
      act_cnt <= '0;
      act_addr <= 32'h0;
      susping <= 1'b0;
      lat_cnt <= '0;
      p_held <= 1'b0;
      e_held <= 1'b0;
      p_cnt <= '0;
      e_cnt <= '0;
      p_addr <= 32'h0;
      e_addr <= 32'h0;
      wel <= 1'b0;
      fsr <= FS_RESET;
    end else begin
      fsr <= next_fsr;
      if (done) wel <= 1'b0;
      if (go_wren) wel <= 1'b1;
      if (!idle && !lat_end) act_cnt <= act_cnt - CW'(1);
      if (done) act <= OP_NONE;
      if (go_susp && !late) begin
        susping <= 1'b1;
        lat_cnt <= CW'(SUSP_LAT_CYC);
      end
      if (susping) lat_cnt <= lat_cnt - CW'(1);
      if (lat_end) begin
        susping <= 1'b0;
        act <= OP_NONE;
        if (act == OP_PROG) begin
          p_held <= 1'b1;
          p_cnt <= act_cnt;
          p_addr <= act_addr;
        end else begin
          e_held <= 1'b1;
          e_cnt <= act_cnt;
          e_addr <= act_addr;
        end
      end
      // Latest suspended first; locks are not checked again
      if (go_res) begin
        act <= p_held ? OP_PROG : OP_ERASE;
        act_cnt <= p_held ? p_cnt : e_cnt;
        act_addr <= p_held ? p_addr : e_addr;
        if (p_held) p_held <= 1'b0;
        else e_held <= 1'b0;
      end
      if (go_prog || go_erase || go_otp) begin
        act <= go_prog ? OP_PROG : go_erase ? OP_ERASE : OP_OTP;
        act_cnt <= go_prog ? CW'(PROG_CYC) : go_erase ? CW'(ERASE_CYC) : CW'(OTP_CYC);
        act_addr <= addr;
      end
    end
  end

  // ****************************************
  // OTP storage
  // ****************************************
  otp_store u_otp (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .stage_clear(stg_clr),
    .stage_we(stg_we),
    .stage_idx(otp_idx),
    .stage_data(rx_byte),
    .commit(otp_commit),
    .rd_idx(otp_idx),
    .rd_data(otp_rdata),
    .locked(locked)
  );
endmodule
`default_nettype wire

// >>> src/sfseq_pkg.sv
// Shared constants for the flash suspend/resume and OTP command sequencer
package sfseq_pkg;
  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [7:0] OPC_WREN = 8'h06;
  localparam logic [7:0] OPC_RDSR = 8'h05;
  localparam logic [7:0] OPC_RDFS = 8'h70;
  localparam logic [7:0] OPC_CLFS = 8'h50;
  localparam logic [7:0] OPC_READ = 8'h03;
  localparam logic [7:0] OPC_PROG = 8'h02;
  localparam logic [7:0] OPC_ERASE = 8'hD8;
  localparam logic [7:0] OPC_SUSP = 8'h75;
  localparam logic [7:0] OPC_RESUME = 8'h7A;
  localparam logic [7:0] OPC_OTP_RD = 8'h4B;
  localparam logic [7:0] OPC_OTP_PROG = 8'h42;

  // ****************************************
  // Status and flag status fields
  // ****************************************
  localparam logic [7:0] SR_WIP_M = 8'h01;
  localparam logic [7:0] SR_WEL_M = 8'h02;
  localparam logic [7:0] FS_READY_M = 8'h80;
  localparam logic [7:0] FS_ESUS_M = 8'h40;
  localparam logic [7:0] FS_PERR_M = 8'h10;
  localparam logic [7:0] FS_PSUS_M = 8'h04;
  localparam logic [7:0] FS_PROT_M = 8'h02;
  localparam logic [7:0] FS_RESET = 8'h80;

  // ****************************************
  // Frame layout and OTP area
  // ****************************************
  localparam logic [7:0] IDX_ADDR_LAST = 8'h04;
  localparam logic [7:0] IDX_READ_DATA = 8'h05;
  localparam logic [7:0] IDX_OTP_DATA = 8'h06;
  localparam logic [7:0] IDX_PROG_DATA = 8'h05;
  localparam logic [6:0] OTP_LAST = 7'h40;
  localparam logic [6:0] OTP_MAX_BYTES = 7'h41;
  localparam int OTP_BYTES = 65;
  localparam int OTP_LOCK_BIT = 0;
  localparam logic [7:0] OTP_BLANK = 8'hFF;
  localparam logic [7:0] UNDEF_BYTE = 8'hFF;
  localparam int SECT_LSB = 17;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 100;
  localparam int SUSP_LAT_NS = 20000;
  localparam int SUSP_LAT_CYC = SUSP_LAT_NS * CLK_MHZ / 1000;
  localparam int PROG_NS = 400000;
  localparam int ERASE_NS = 2000000;
  localparam int OTP_PROG_NS = 400000;

  // ****************************************
  // State encodings
  // ****************************************
  typedef enum logic [3:0] {
    OP_NONE = 4'b0001, OP_PROG = 4'b0010, OP_ERASE = 4'b0100, OP_OTP = 4'b1000
  } op_t;
  typedef enum logic [2:0] {H_IDLE = 3'b001, H_RUN = 3'b010, H_GAP = 3'b100} hst_t;
endpackage

// >>> src/sfseq_if.sv
// Link interface joining the host controller and the flash sequencer
`timescale 1ns/100ps
`default_nettype none
interface sfseq_if;
  logic cs_n;
  logic sck;
  logic [7:0] host_io;
  logic [7:0] host_oe_n;
  logic [7:0] dev_io;
  logic [7:0] dev_oe_n;
  logic [7:0] serial_io_lines;
  // Host drive first, then device, else the line is pulled high
  assign serial_io_lines = (~host_oe_n & host_io) | (host_oe_n & ~dev_oe_n & dev_io)
    | (host_oe_n & dev_oe_n);
  modport host (output cs_n, output sck, output host_io, output host_oe_n,
    input serial_io_lines);
  modport dev (input cs_n, input sck, input serial_io_lines, output dev_io, output dev_oe_n);
endinterface
`default_nettype wire

// >>> src/otp_store.sv
// OTP array with its staging buffer and permanent lock byte
`timescale 1ns/100ps
`default_nettype none
module otp_store import sfseq_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Staging side
  input wire logic stage_clear,
  input wire logic stage_we,
  input wire logic [6:0] stage_idx,
  input wire logic [7:0] stage_data,
  input wire logic commit,
  // Read side
  input wire logic [6:0] rd_idx,
  output logic [7:0] rd_data,
  output logic locked
);
  logic [7:0] mem [OTP_BYTES];
  logic [7:0] stage [OTP_BYTES];

  // Indices past the control byte occur only after it is staged; they read blank
  assign rd_data = (rd_idx <= OTP_LAST) ? mem[rd_idx] : OTP_BLANK;
  assign locked = !mem[OTP_BYTES - 1][OTP_LOCK_BIT];

  // Programming only clears bits, so a cleared lock bit stays cleared
  always_ff @(posedge clk) begin
    for (int i = 0; i < OTP_BYTES; i++) begin
      if (!rst_n) begin
        mem[i] <= OTP_BLANK;
        stage[i] <= OTP_BLANK;
      end else begin
        if (stage_clear) begin
          stage[i] <= OTP_BLANK;
        end else if (stage_we && stage_idx == 7'(i)) begin
          stage[i] <= stage_data;
        end
        if (commit) begin
          mem[i] <= mem[i] & stage[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> src/sfseq_host.sv
// Host end: frames commands on the link and polls for ready
`timescale 1ns/100ps
`default_nettype none
module sfseq_host import sfseq_pkg::*; #(
  parameter int SCK_HALF = 8
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // Link pins
  sfseq_if.host LINK,
  // Configuration
  input wire logic OCTAL,
  // Command request
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic [7:0] CMD_CODE,
  input wire logic [31:0] CMD_ADDR,
  input wire logic CMD_ADDR_EN,
  input wire logic [3:0] CMD_DUMMY,
  input wire logic [7:0] CMD_NTX,
  input wire logic [7:0] CMD_NRX,
  input wire logic CMD_POLL,
  // Data and completion
  input wire logic [7:0] TX_DATA,
  output logic TX_TAKE,
  output logic [7:0] RX_DATA,
  output logic RX_VALID,
  output logic DONE
);
  hst_t st;
  logic [7:0] in_m;
  logic [7:0] in_s;
  logic [7:0] div;
  logic [2:0] bcnt;
  logic [8:0] bidx;
  logic [7:0] tx;
  logic [7:0] rx;
  logic [31:0] a_sh;
  logic [8:0] a_end;
  logic [8:0] d_end;
  logic [8:0] t_end;
  logic [8:0] total;
  logic polling;
  logic poll_next;
  logic drv;
  logic cs_n;
  logic sck;
  logic gap_ph;

  // Frame segment decode for the next byte
  wire tick = div == 8'(SCK_HALF - 1);
  wire last_bit = OCTAL | (bcnt == 3'h7);
  wire [8:0] nidx = bidx + 9'h001;
  wire [7:0] rx_next = OCTAL ? in_s : {rx[6:0], in_s[1]};
  wire in_rx = bidx >= t_end;
  wire is_tx = (nidx >= d_end) & (nidx < t_end);
  wire [7:0] nbyte = (nidx < a_end) ? a_sh[31:24] : is_tx ? TX_DATA : 8'h00;

  assign CMD_READY = st == H_IDLE;
  assign LINK.cs_n = cs_n;
  assign LINK.sck = sck;
  assign LINK.host_io = OCTAL ? tx : {7'h00, tx[7]};
  assign LINK.host_oe_n = !drv ? 8'hFF : OCTAL ? 8'h00 : 8'hFE;

  // Returned data enters through two flops like any pin
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      in_m <= 8'h00;
      in_s <= 8'h00;
    end else begin
      in_m <= LINK.serial_io_lines;
      in_s <= in_m;
    end
  end

  // Frame sequencer: output changes after falling edges, input sampled at rising ones
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      st <= H_IDLE;
      cs_n <= 1'b1;
      sck <= 1'b0;
      gap_ph <= 1'b0;
      div <= 8'h00;
      bcnt <= 3'h0;
      bidx <= 9'h000;
      tx <= 8'h00;
      rx <= 8'h00;
      a_sh <= 32'h0;
      {a_end, d_end, t_end, total} <= '0;
      polling <= 1'b0;
      poll_next <= 1'b0;
      drv <= 1'b0;
      TX_TAKE <= 1'b0;
      RX_DATA <= 8'h00;
      RX_VALID <= 1'b0;
      DONE <= 1'b0;
    end else begin
      TX_TAKE <= 1'b0;
      RX_VALID <= 1'b0;
      DONE <= 1'b0;
      div <= tick ? 8'h00 : div + 8'h01;
      unique case (st)
        H_IDLE: begin
          div <= 8'h00;
          if (CMD_VALID) begin
            st <= H_RUN;
            cs_n <= 1'b0;
            drv <= 1'b1;
            tx <= CMD_CODE;
            a_sh <= CMD_ADDR;
            a_end <= CMD_ADDR_EN ? 9'h005 : 9'h001;
            d_end <= (CMD_ADDR_EN ? 9'h005 : 9'h001) + {5'h00, CMD_DUMMY};
            t_end <= (CMD_ADDR_EN ? 9'h005 : 9'h001) + {5'h00, CMD_DUMMY} + {1'b0, CMD_NTX};
            total <= (CMD_ADDR_EN ? 9'h005 : 9'h001) + {5'h00, CMD_DUMMY} + {1'b0, CMD_NTX}
              + {1'b0, CMD_NRX};
            poll_next <= CMD_POLL;
            bcnt <= 3'h0;
            bidx <= 9'h000;
          end
        end
        H_RUN: begin
          if (tick && !sck) begin
            sck <= 1'b1;
            rx <= rx_next;
            if (in_rx && last_bit) begin
              RX_DATA <= rx_next;
              RX_VALID <= 1'b1;
              if (polling && rx_next[7]) poll_next <= 1'b0;
            end
          end else if (tick) begin
            sck <= 1'b0;
            bcnt <= OCTAL ? 3'h0 : bcnt + 3'h1;
            if (!last_bit) begin
              tx <= {tx[6:0], 1'b0};
            end else if (nidx >= total) begin
              st <= H_GAP;
              cs_n <= 1'b1;
              drv <= 1'b0;
            end else begin
              bidx <= nidx;
              tx <= nbyte;
              if (nidx < a_end) a_sh <= {a_sh[23:0], 8'h00};
              TX_TAKE <= is_tx;
              drv <= nidx < t_end;
            end
          end
        end
        H_GAP: begin
          // Gap timed on its own phase bit so the link clock stays low outside frames
          if (tick && gap_ph) begin
            gap_ph <= 1'b0;
            if (poll_next) begin
              // Re-read flag status until the ready bit shows
              st <= H_RUN;
              polling <= 1'b1;
              cs_n <= 1'b0;
              drv <= 1'b1;
              tx <= OPC_RDFS;
              {a_end, d_end, t_end} <= {9'h001, 9'h001, 9'h001};
              total <= 9'h002;
              bcnt <= 3'h0;
              bidx <= 9'h000;
            end else begin
              st <= H_IDLE;
              polling <= 1'b0;
              DONE <= 1'b1;
            end
          end else if (tick) begin
            gap_ph <= 1'b1;
          end
        end
        default: st <= H_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> tb/sfseq_link_monitor.sv
// Wire-level checks on the link between host and flash ends
`timescale 1ns/100ps
`default_nettype none
module sfseq_link_monitor (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // Link signals
  input wire logic cs_n,
  input wire logic sck,
  input wire logic [7:0] host_io,
  input wire logic [7:0] host_oe_n,
  input wire logic [7:0] dev_io,
  input wire logic [7:0] dev_oe_n
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // High phase is one host half period, eight cycles by default
  sequence high_phase;
    sck [*8] ##1 !sck;
  endsequence
  sequence gap_phase;
    cs_n [*8];
  endsequence
  sck_half_a: assert property ($rose(sck) |-> high_phase)
    else $error("serial clock high phase has the wrong length");
  frame_gap_a: assert property ($rose(cs_n) |-> gap_phase)
    else $error("chip select gap too short");
  cs_edge_a: assert property ($changed(cs_n) |-> !sck)
    else $error("chip select moved while serial clock high");
  sck_idle_a: assert property (cs_n && $past(cs_n) |-> !sck)
    else $error("serial clock runs outside a frame");
  dev_release_a: assert property (cs_n [*4] |-> dev_oe_n == 8'hFF)
    else $error("device drives lines while deselected");
  no_clash_a: assert property ((~host_oe_n & ~dev_oe_n) == 8'h00)
    else $error("host and device drive one line together");
  // Data may only change while the clock is low, so rising edges see settled bits
  host_hold_a: assert property (sck && $past(sck) |-> $stable(host_io & ~host_oe_n))
    else $error("host data changed while serial clock high");
  dev_hold_a: assert property (sck && $past(sck) |-> $stable(dev_io & ~dev_oe_n))
    else $error("device data changed while serial clock high");
endmodule
`default_nettype wire

// >>> tb/suspend_resume_otp_sequencer_tb.sv
// Bench: host and flash ends joined on the link, checked against a byte model
`timescale 1ns/100ps
`default_nettype none
module suspend_resume_otp_sequencer_tb import sfseq_pkg::*; ;
  logic clk = 0, rst_n = 0, valid = 0, aen = 0, pl = 0, octal = 0, fail = 0;
  logic rdy, take, rxv, done;
  logic [7:0] code = 0, ntx = 0, nrx = 0, rxd;
  logic [3:0] dm = 0;
  logic [31:0] addr = 0, aaddr;
  logic [7:0] txb [80];
  logic [7:0] otp [65];
  logic [7:0] rxq [$];
  int txi = 0, failures = 0, samples_checked = 0, seed = 32'h7189;
  sfseq_if link ();
  always #5 clk = ~clk;
  // Short self-timed counts keep the run brief; program stays above the latency
  sfseq_host u_sfseq_host (.SYS_CLK(clk), .RST_N(rst_n), .LINK(link), .OCTAL(octal),
    .CMD_VALID(valid), .CMD_READY(rdy), .CMD_CODE(code), .CMD_ADDR(addr), .CMD_ADDR_EN(aen),
    .CMD_DUMMY(dm), .CMD_NTX(ntx), .CMD_NRX(nrx), .CMD_POLL(pl), .TX_DATA(txb[txi]),
    .TX_TAKE(take), .RX_DATA(rxd), .RX_VALID(rxv), .DONE(done));
  sfseq_dev #(.PROG_CYC(3000), .ERASE_CYC(4000), .OTP_CYC(300)) u_sfseq_dev (.SYS_CLK(clk),
    .RST_N(rst_n), .LINK(link), .OCTAL(octal), .OTP_FAIL(fail), .ARRAY_ADDR(aaddr),
    .ARRAY_RDATA(aaddr[7:0] ^ 8'h5A));
  sfseq_link_monitor u_monitor (.SYS_CLK(clk), .RST_N(rst_n), .cs_n(link.cs_n),
    .sck(link.sck), .host_io(link.host_io), .host_oe_n(link.host_oe_n),
    .dev_io(link.dev_io), .dev_oe_n(link.dev_oe_n));
  task automatic complete_run();
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  // One frame; width changes per frame, only while both ends are idle
  task automatic cmd(input logic [7:0] c, input logic [31:0] a, input logic [7:0] n,
    input logic [7:0] r, input logic p);
    @(negedge clk);
    octal = 1'($random(seed));
    code = c;
    addr = a;
    aen = c inside {OPC_READ, OPC_PROG, OPC_ERASE, OPC_OTP_RD, OPC_OTP_PROG};
    dm = (c == OPC_OTP_RD) ? 4'h1 : 4'h0;
    ntx = n;
    nrx = r;
    pl = p;
    txi = 0;
    valid = 1;
    @(negedge clk);
    valid = 0;
    rxq.delete();
    // A frame that never ends is caught by the watchdog
    while (!done) begin
      @(negedge clk);
      if (rxv) rxq.push_back(rxd);
      if (take) txi++;
    end
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] m, input logic [7:0] e);
    cmd(c, 0, 0, 1, 0);
    chk(c == OPC_RDFS ? "flags" : "status", e, rxq[0] & m);
  endtask
  // Watchdog: the tests need about 30k cycles, so 50k leaves ample margin
  initial begin
    #500000;
    failures++;
    complete_run();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    for (int i = 0; i < 80; i++) txb[i] = 8'($random(seed));
    txb[64][0] = 1'b1;
    for (int i = 0; i < 65; i++) otp[i] = OTP_BLANK;
    repeat (3) @(negedge clk);
    rst_n = 1;
    rd(OPC_RDFS, 8'hFF, FS_RESET);
    rd(OPC_RDSR, 8'hFF, 8'h00);
    $display("test reset done");
    cmd(OPC_SUSP, 0, 0, 0, 0);
    rd(OPC_RDFS, 8'hFF, FS_RESET);
    cmd(OPC_RESUME, 0, 0, 0, 0);
    rd(OPC_RDSR, 8'hFF, 8'h00);
    cmd(OPC_OTP_PROG, 0, 2, 0, 0);
    rd(OPC_RDFS, 8'hFF, FS_RESET);
    $display("test standby done");
    cmd(OPC_WREN, 0, 0, 0, 0);
    cmd(OPC_OTP_PROG, 0, 66, 0, 1);
    for (int i = 0; i < 65; i++) otp[i] &= txb[i];
    rd(OPC_RDSR, 8'hFF, 8'h00);
    cmd(OPC_OTP_RD, 32'h3E, 0, 4, 0);
    for (int i = 0; i < 4; i++) chk("otp", otp[i < 2 ? 62 + i : 64], rxq[i]);
    txb[0] = 8'hFF;
    fail = 1;
    cmd(OPC_WREN, 0, 0, 0, 0);
    cmd(OPC_OTP_PROG, 0, 1, 0, 1);
    fail = 0;
    rd(OPC_RDFS, 8'hFF, FS_READY_M | FS_PERR_M);
    rd(OPC_RDSR, 8'hFF, 8'h00);
    cmd(OPC_CLFS, 0, 0, 0, 0);
    $display("test otp done");
    cmd(OPC_WREN, 0, 0, 0, 0);
    cmd(OPC_PROG, 0, 1, 0, 0);
    cmd(OPC_SUSP, 0, 0, 0, 1);
    chk("flags", FS_READY_M | FS_PSUS_M, rxq[rxq.size() - 1]);
    cmd(OPC_READ, 32'h10, 0, 1, 0);
    chk("array", UNDEF_BYTE, rxq[0]);
    cmd(OPC_READ, 32'h40010, 0, 1, 0);
    chk("array", 8'h4A, rxq[0]);
    cmd(OPC_RESUME, 0, 0, 0, 0);
    rd(OPC_RDSR, SR_WIP_M, SR_WIP_M);
    rd(OPC_RDFS, 8'hFF, 8'h00);
    cmd(OPC_RDFS, 0, 0, 1, 1);
    chk("flags", FS_READY_M, rxq[rxq.size() - 1]);
    $display("test suspend done");
    cmd(OPC_WREN, 0, 0, 0, 0);
    cmd(OPC_PROG, 0, 1, 0, 0);
    repeat (1500) @(negedge clk);
    cmd(OPC_SUSP, 0, 0, 0, 1);
    chk("flags", FS_PSUS_M, rxq[0]);
    chk("flags", FS_READY_M, rxq[rxq.size() - 1]);
    cmd(OPC_WREN, 0, 0, 0, 0);
    cmd(OPC_ERASE, 32'h20000, 0, 0, 0);
    cmd(OPC_SUSP, 0, 0, 0, 1);
    chk("flags", FS_READY_M | FS_ESUS_M, rxq[rxq.size() - 1]);
    cmd(OPC_PROG, 32'h20010, 1, 0, 0);
    rd(OPC_RDFS, 8'hFF, FS_READY_M | FS_ESUS_M | FS_PERR_M);
    rd(OPC_RDSR, 8'hFF, SR_WEL_M);
    cmd(OPC_CLFS, 0, 0, 0, 0);
    cmd(OPC_PROG, 0, 1, 0, 0);
    cmd(OPC_SUSP, 0, 0, 0, 1);
    chk("flags", FS_READY_M | FS_ESUS_M | FS_PSUS_M, rxq[rxq.size() - 1]);
    cmd(OPC_READ, 32'h20005, 0, 1, 0);
    chk("array", UNDEF_BYTE, rxq[0]);
    cmd(OPC_RESUME, 0, 0, 0, 0);
    cmd(OPC_RDFS, 0, 0, 1, 1);
    chk("flags", FS_READY_M | FS_ESUS_M, rxq[rxq.size() - 1]);
    cmd(OPC_RESUME, 0, 0, 0, 0);
    cmd(OPC_RDFS, 0, 0, 1, 1);
    chk("flags", FS_READY_M, rxq[rxq.size() - 1]);
    $display("test nesting done");
    txb[0] = 8'hFE;
    cmd(OPC_WREN, 0, 0, 0, 0);
    cmd(OPC_OTP_PROG, 32'h40, 1, 0, 1);
    otp[64] &= 8'hFE;
    cmd(OPC_WREN, 0, 0, 0, 0);
    cmd(OPC_OTP_PROG, 0, 1, 0, 0);
    rd(OPC_RDFS, 8'hFF, FS_READY_M | FS_PERR_M | FS_PROT_M);
    rd(OPC_RDSR, 8'hFF, SR_WEL_M);
    cmd(OPC_OTP_RD, 32'h40, 0, 1, 0);
    chk("otp", otp[64], rxq[0]);
    $display("test lock done");
    complete_run();
  end
endmodule
`default_nettype wire
